// [rtl/bie_pkg.sv]
// Package with encodings, field positions and register map of the instruction executor
package bie_pkg;
   // Instruction word geometry
   localparam int             IW          = 12;
   localparam int             PCW         = 11;
   localparam int             DW          = 8;
   localparam int             FAW         = 5;
   localparam int             PMAW        = 11;
   localparam int             Q_PER_CYCLE = 4;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bie_phase_e;

   // Opcode fields, byte format bits 11:6
   localparam logic [5:0]     OP_ADD_W = 6'h07;
   localparam logic [5:0]     OP_AND_W = 6'h05;
   localparam logic [5:0]     OP_OR_W  = 6'h04;
   localparam logic [5:0]     OP_INV_F = 6'h09;
   localparam logic [5:0]     OP_MOV_F = 6'h08;
   // Bits 11:5 for move, clear file and clear working
   localparam logic [6:0]     OP_W_TO_F = 7'h01;
   localparam logic [6:0]     OP_ZERO_F = 7'h03;
   localparam logic [6:0]     OP_ZERO_W = 7'h02;
   // Bit and literal formats, bits 11:8
   localparam logic [3:0]     OP_BIT_CLR  = 4'h4;
   localparam logic [3:0]     OP_BIT_SET  = 4'h5;
   localparam logic [3:0]     OP_SKIP_CLR = 4'h6;
   localparam logic [3:0]     OP_SKIP_SET = 4'h7;
   localparam logic [3:0]     OP_CALL     = 4'h9;
   localparam logic [3:0]     OP_LIT_W    = 4'hC;
   localparam logic [3:0]     OP_AND_LIT  = 4'hE;
   // Jump format, bits 11:9
   localparam logic [2:0]     OP_GOTO  = 3'h5;
   // Whole-word control instructions
   localparam logic [IW-1:0]  INSN_NOP    = 12'h000;
   localparam logic [IW-1:0]  INSN_WDOG_CLR = 12'h004;
   localparam logic [IW-1:0]  INSN_OPTION = 12'h002;

   // Status bit positions, then the option bit that assigns the prescaler
   localparam int             ST_C    = 0;
   localparam int             ST_HC   = 1;
   localparam int             ST_Z    = 2;
   localparam int             ST_PDN  = 3;
   localparam int             ST_TON  = 4;
   localparam int             ST_PA0  = 5;
   localparam int             ST_PA1  = 6;
   localparam int             OPT_PSA = 3;
   // File addresses decoded inside the core
   localparam logic [FAW-1:0] F_PCL    = 5'h02;
   localparam logic [FAW-1:0] F_STATUS = 5'h03;

   // Reset values
   localparam logic [7:0]     STATUS_RST = 8'h18;
   localparam logic [7:0]     OPTION_RST = 8'hFF;

   // APB register map, byte addresses
   localparam logic [7:0]     A_CTRL  = 8'h00;
   localparam logic [7:0]     A_CORE  = 8'h04;
   localparam logic [7:0]     A_PCREG = 8'h08;
   localparam logic [7:0]     A_PMEM  = 8'h0C;
   localparam logic [7:0]     A_WDOG  = 8'h10;
   localparam int             PMEM_ADDR_LSB = 16;
endpackage : bie_pkg

// [rtl/bie_mem_if.sv]
// Interface carrying one synchronous memory port
`timescale 1ns/100ps
`default_nettype none
interface bie_mem_if #(parameter int DW = 8, parameter int AW = 5);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : bie_mem_if
`default_nettype wire

// [rtl/bie_mem.sv]
// Single-port memory with registered read data, used for program and file storage
`timescale 1ns/100ps
`default_nettype none
module bie_mem #(
   parameter int DW = 8,
   parameter int AW = 5
) (
   input  wire logic  pclk,
   bie_mem_if.mem     port
);
   logic [DW-1:0] store [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   // Read-before-write; no reset so the array maps onto plain RAM
   always_ff @(posedge pclk) begin
      if (port.en) begin
         rdata_r <= store[port.addr];
         if (port.we) begin
            store[port.addr] <= port.wdata;
         end
      end
   end

   assign port.rdata = rdata_r;
endmodule : bie_mem
`default_nettype wire

// [rtl/bie_seq.sv]
// Four-phase sequencer that splits each instruction cycle into oscillator periods
`timescale 1ns/100ps
`default_nettype none
module bie_seq (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              run,
   output bie_pkg::bie_phase_e    phase
);
   bie_pkg::bie_phase_e phase_r;

   // Parks in the first phase while stopped, so a restart always begins a whole cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= bie_pkg::PH_Q1;
      end else begin
         unique case (phase_r)
            bie_pkg::PH_Q1: phase_r <= run ? bie_pkg::PH_Q2 : bie_pkg::PH_Q1;
            bie_pkg::PH_Q2: phase_r <= bie_pkg::PH_Q3;
            bie_pkg::PH_Q3: phase_r <= bie_pkg::PH_Q4;
            bie_pkg::PH_Q4: phase_r <= bie_pkg::PH_Q1;
         endcase
      end
   end

   assign phase = phase_r;
endmodule : bie_seq
`default_nettype wire

// [rtl/bie_core.sv]
// Instruction fetch, decode and execute core with APB control access
// What this block does
// - One instruction cycle per instruction; skips and PC loads take two.
// - Each instruction cycle is four consecutive clock periods.
// - Destination bit 0 writes working register, 1 writes file register.
// - Byte format: opcode 11:6, destination 5, file address 4:0.
// - Bit format: bit number 7:5, file address 4:0.
// - Add working to file: sum to destination, update carry, half carry, zero.
// - AND working with file: result to destination, zero flag only.
// - OR working with file: result to destination, zero flag only.
// - Complement file: inverted value to destination, zero flag only.
// - AND literal: working AND low byte into working, update zero.
// - Bit clear and set force the bit, flags unchanged.
// - Bit tests skip by flushing the prefetched word into a no-op.
// - Clear working loads zero and sets zero flag.
// - Clear file writes zero and sets zero flag.
// - Call pushes PC+1, loads literal, page bits from status, bit 8 cleared.
// - Watchdog clear zeros counter, prescaler if assigned, sets both status flags.
// - Move working to file copies without touching flags.
// - Move file copies to destination and updates zero flag.
// - Move literal loads working register, flags unchanged.
// - Load option copies working register into option register.
`timescale 1ns/100ps
`default_nettype none
module bie_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [7:0]  option_out
);
   bie_pkg::bie_phase_e  phase;
   logic                 run_r;
   logic [7:0]           w_r;
   logic [7:0]           w_nxt;
   logic [7:0]           status_r;
   logic [7:0]           status_nxt;
   logic [7:0]           option_r;
   logic [10:0]          pc_r;
   logic [10:0]          stack_top_r;
   logic [10:0]          stack_low_r;
   logic [11:0]          ir_r;
   logic                 flush_r;
   logic [7:0]           wdt_r;
   logic [7:0]           presc_r;
   logic [31:0]          prdata_r;
   logic                 pready_r;
   logic                 pslverr_r;
   logic [7:0]           fval;
   logic [7:0]           res;
   logic                 to_w;
   logic                 to_f;
   logic                 upd_z;
   logic                 upd_cdc;
   logic                 carry;
   logic                 half;
   logic                 skip;
   logic                 jump;
   logic                 call;
   logic                 wdog_clr;
   logic                 ld_option;
   logic [10:0]          target;
   logic [8:0]           sum9;
   logic [4:0]           sum5;
   logic                 apb_wr;
   logic                 exec;
   logic [7:0]           mask;

   bie_mem_if #(.DW(8), .AW(bie_pkg::FAW))   dmem_if ();
   bie_mem_if #(.DW(12), .AW(bie_pkg::PMAW)) pmem_if ();

   bie_seq u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run_r),
      .phase   (phase)
   );

   bie_mem #(.DW(8), .AW(bie_pkg::FAW)) u_dmem (
      .pclk (pclk),
      .port (dmem_if.mem)
   );

   bie_mem #(.DW(12), .AW(bie_pkg::PMAW)) u_pmem (
      .pclk (pclk),
      .port (pmem_if.mem)
   );

   // One-hot mask for the bit number field, shared by set, clear and test
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction : bit_mask

   assign exec   = run_r && (phase == bie_pkg::PH_Q4);
   assign apb_wr = psel && penable && pwrite && pready_r;
   assign mask   = bit_mask(ir_r[7:5]);

   // File read mux: status and PC low live in the core, the rest in RAM
   always_comb begin
      if (ir_r[4:0] == bie_pkg::F_STATUS) begin
         fval = status_r;
      end else if (ir_r[4:0] == bie_pkg::F_PCL) begin
         fval = pc_r[7:0];
      end else begin
         fval = dmem_if.rdata;
      end
   end

   assign sum9 = {1'b0, w_r} + {1'b0, fval};
   assign sum5 = {1'b0, w_r[3:0]} + {1'b0, fval[3:0]};

   // Decode and compute; a flushed slot behaves as a no-op
   always_comb begin
      res       = 8'h00;
      to_w      = 1'b0;
      to_f      = 1'b0;
      upd_z     = 1'b0;
      upd_cdc   = 1'b0;
      carry     = sum9[8];
      half      = sum5[4];
      skip      = 1'b0;
      jump      = 1'b0;
      call      = 1'b0;
      wdog_clr  = 1'b0;
      ld_option = 1'b0;
      target    = 11'h000;
      if (!flush_r) begin
         if (ir_r[11:6] == bie_pkg::OP_ADD_W) begin
            res     = sum9[7:0];
            upd_z   = 1'b1;
            upd_cdc = 1'b1;
            to_w    = !ir_r[5];
            to_f    = ir_r[5];
         end else if (ir_r[11:6] == bie_pkg::OP_AND_W) begin
            res   = w_r & fval;
            upd_z = 1'b1;
            to_w  = !ir_r[5];
            to_f  = ir_r[5];
         end else if (ir_r[11:6] == bie_pkg::OP_OR_W) begin
            res   = w_r | fval;
            upd_z = 1'b1;
            to_w  = !ir_r[5];
            to_f  = ir_r[5];
         end else if (ir_r[11:6] == bie_pkg::OP_INV_F) begin
            res   = ~fval;
            upd_z = 1'b1;
            to_w  = !ir_r[5];
            to_f  = ir_r[5];
         end else if (ir_r[11:6] == bie_pkg::OP_MOV_F) begin
            res   = fval;
            upd_z = 1'b1;
            to_w  = !ir_r[5];
            to_f  = ir_r[5];
         end else if (ir_r[11:5] == bie_pkg::OP_W_TO_F) begin
            res  = w_r;
            to_f = 1'b1;
         end else if (ir_r[11:5] == bie_pkg::OP_ZERO_F) begin
            res   = 8'h00;
            upd_z = 1'b1;
            to_f  = 1'b1;
         end else if (ir_r == {bie_pkg::OP_ZERO_W, 5'h00}) begin
            res   = 8'h00;
            upd_z = 1'b1;
            to_w  = 1'b1;
         end else if (ir_r == bie_pkg::INSN_WDOG_CLR) begin
            wdog_clr = 1'b1;
         end else if (ir_r == bie_pkg::INSN_OPTION) begin
            ld_option = 1'b1;
         end else if (ir_r[11:8] == bie_pkg::OP_BIT_CLR) begin
            res  = fval & ~mask;
            to_f = 1'b1;
         end else if (ir_r[11:8] == bie_pkg::OP_BIT_SET) begin
            res  = fval | mask;
            to_f = 1'b1;
         end else if (ir_r[11:8] == bie_pkg::OP_SKIP_CLR) begin
            skip = ((fval & mask) == 8'h00);
         end else if (ir_r[11:8] == bie_pkg::OP_SKIP_SET) begin
            skip = ((fval & mask) != 8'h00);
         end else if (ir_r[11:8] == bie_pkg::OP_CALL) begin
            call   = 1'b1;
            target = {status_r[bie_pkg::ST_PA1], status_r[bie_pkg::ST_PA0], 1'b0,
                      ir_r[7:0]};
         end else if (ir_r[11:9] == bie_pkg::OP_GOTO) begin
            jump   = 1'b1;
            target = {status_r[bie_pkg::ST_PA1], status_r[bie_pkg::ST_PA0],
                      ir_r[8:0]};
         end else if (ir_r[11:8] == bie_pkg::OP_LIT_W) begin
            res  = ir_r[7:0];
            to_w = 1'b1;
         end else if (ir_r[11:8] == bie_pkg::OP_AND_LIT) begin
            res   = w_r & ir_r[7:0];
            upd_z = 1'b1;
            to_w  = 1'b1;
         end
      end
   end

   // Data RAM: read in the first phase, write back in the last
   assign dmem_if.en    = run_r && ((phase == bie_pkg::PH_Q1) || exec);
   assign dmem_if.we    = exec && to_f && (ir_r[4:0] != bie_pkg::F_STATUS)
                          && (ir_r[4:0] != bie_pkg::F_PCL);
   assign dmem_if.addr  = ir_r[4:0];
   assign dmem_if.wdata = res;

   // Program memory: fetch while running, loaded over APB only while stopped
   assign pmem_if.en    = run_r ? (phase == bie_pkg::PH_Q1)
                                : (apb_wr && (paddr == bie_pkg::A_PMEM));
   assign pmem_if.we    = !run_r;
   assign pmem_if.addr  = run_r ? pc_r : pwdata[bie_pkg::PMEM_ADDR_LSB +: bie_pkg::PMAW];
   assign pmem_if.wdata = pwdata[11:0];

   // Working register update
   always_comb begin
      w_nxt = w_r;
      if (exec && to_w) begin
         w_nxt = res;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_r <= 8'h00;
      end else begin
         w_r <= w_nxt;
      end
   end

   // Status: direct writes keep the two watchdog flags, then flag updates win
   always_comb begin
      status_nxt = status_r;
      if (exec) begin
         if (to_f && (ir_r[4:0] == bie_pkg::F_STATUS)) begin
            status_nxt = {res[7:5], status_r[4:3], res[2:0]};
         end
         if (upd_z) begin
            status_nxt[bie_pkg::ST_Z] = (res == 8'h00);
         end
         if (upd_cdc) begin
            status_nxt[bie_pkg::ST_C]  = carry;
            status_nxt[bie_pkg::ST_HC] = half;
         end
         if (wdog_clr) begin
            status_nxt[bie_pkg::ST_TON] = 1'b1;
            status_nxt[bie_pkg::ST_PDN] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= bie_pkg::STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Option register for timer and prescaler setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         option_r <= bie_pkg::OPTION_RST;
      end else if (exec && ld_option) begin
         option_r <= w_r;
      end
   end

   // Fetch: prefetched word becomes current, or a no-op after a PC change or skip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r    <= 11'h000;
         ir_r    <= bie_pkg::INSN_NOP;
         flush_r <= 1'b0;
      end else if (exec) begin
         pc_r    <= (call || jump) ? target : pc_r + 11'h001;
         ir_r    <= pmem_if.rdata;
         flush_r <= skip || call || jump;
      end
   end

   // Two-level return stack; push shifts the old top down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_top_r <= 11'h000;
         stack_low_r <= 11'h000;
      end else if (exec && call) begin
         stack_top_r <= pc_r;
         stack_low_r <= stack_top_r;
      end
   end

   // Watchdog counter advances once per instruction cycle, or once per 256 through the prescaler when it is assigned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_r   <= 8'h00;
         presc_r <= 8'h00;
      end else if (exec) begin
         if (wdog_clr) begin
            wdt_r <= 8'h00;
            if (option_r[bie_pkg::OPT_PSA]) begin
               presc_r <= 8'h00;
            end
         end else if (option_r[bie_pkg::OPT_PSA]) begin
            presc_r <= presc_r + 8'h01;
            if (presc_r == 8'hFF) begin
               wdt_r <= wdt_r + 8'h01;
            end
         end else begin
            wdt_r <= wdt_r + 8'h01;
         end
      end
   end

   // Run control written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else if (apb_wr && (paddr == bie_pkg::A_CTRL)) begin
         run_r <= pwdata[0];
      end
   end

   // APB answer prepared in the setup phase, so the access phase never waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= psel && !penable;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               bie_pkg::A_CTRL:  prdata_r <= {31'h0000_0000, run_r};
               bie_pkg::A_CORE:  prdata_r <= {8'h00, option_r, status_r, w_r};
               bie_pkg::A_PCREG: prdata_r <= {5'h00, stack_top_r, 5'h00, pc_r};
               bie_pkg::A_PMEM:  prdata_r <= 32'h0000_0000;
               bie_pkg::A_WDOG:  prdata_r <= {16'h0000, presc_r, wdt_r};
               default:          pslverr_r <= 1'b1;
            endcase
         end
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign option_out = option_r;
endmodule : bie_core
`default_nettype wire

// [tb/bie_core_asserts.sv]
// Concurrent checks on the register bus side of the instruction executor core
`timescale 1ns/100ps
`default_nettype none
module bie_core_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  option_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Address decode kept apart so the error checks read plainly
   logic mapped;
   logic rd_core;
   assign mapped  = paddr inside {bie_pkg::A_CTRL, bie_pkg::A_CORE, bie_pkg::A_PCREG,
                                  bie_pkg::A_PMEM, bie_pkg::A_WDOG};
   assign rd_core = pready && !pwrite && (paddr == bie_pkg::A_CORE);

   // Zero wait states: answer in the cycle right after setup
   setup_gets_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   idle_quiet_a: assert property ((!psel) [*2] |-> !pready && !pslverr)
      else $error("answer while bus idle");
   unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   pmem_read_zero_a: assert property (pready && !pwrite && paddr == bie_pkg::A_PMEM
                                      |-> prdata == 32'h0)
      else $error("write-only word read back data");
   core_option_a: assert property (rd_core |-> prdata[23:16] == option_out)
      else $error("option pin and core word disagree");
   flags_high_a: assert property (rd_core |-> prdata[12:11] == 2'b11)
      else $error("timeout or powerdown flag low");
   option_reset_a: assert property ($rose(presetn) |-> option_out == 8'hFF)
      else $error("option register not at reset value");

   // Main scenarios reached
   cover property (pready && pslverr);
   cover property (rd_core && prdata[7:0] != 8'h00);
   cover property ($changed(option_out));
endmodule : bie_core_asserts
`default_nettype wire

// [tb/test_baseline_instruction_executor.sv]
// Self-checking bench that loads small programs and reads back core state
`timescale 1ns/100ps
`default_nettype none
module test_baseline_instruction_executor;
   typedef struct packed {
      logic [11:0] op;
      logic        post;
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  ew;
      logic [7:0]  est;
      logic [7:0]  eopt;
   } bie_row_s;

   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  option_out;
   int          n_errors = 0;
   int          n_tests  = 0;

   // File 0x10 holds a, W holds b, then the op; post copies the file back into W
   bie_row_s rows [15] = '{
      '{{bie_pkg::OP_ADD_W, 1'b0, 5'h10}, 1'b0, 8'h0F, 8'h01, 8'h10, 8'h1A, 8'hFF},
      '{{bie_pkg::OP_ADD_W, 1'b1, 5'h10}, 1'b1, 8'hFF, 8'h01, 8'h00, 8'h1F, 8'hFF},
      '{{bie_pkg::OP_AND_W, 1'b0, 5'h10}, 1'b0, 8'hF0, 8'h0F, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_OR_W, 1'b1, 5'h10}, 1'b1, 8'hA0, 8'h05, 8'hA5, 8'h18, 8'hFF},
      '{{bie_pkg::OP_INV_F, 1'b0, 5'h10}, 1'b0, 8'hFF, 8'h12, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_MOV_F, 1'b0, 5'h10}, 1'b0, 8'h00, 8'h33, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_MOV_F, 1'b1, 5'h10}, 1'b0, 8'h00, 8'h33, 8'h33, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_AND_LIT, 8'hF0}, 1'b0, 8'h00, 8'h0F, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_ZERO_W, 5'h00}, 1'b0, 8'h00, 8'h55, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_ZERO_F, 5'h10}, 1'b1, 8'h99, 8'h55, 8'h00, 8'h1C, 8'hFF},
      '{{bie_pkg::OP_BIT_SET, 3'h7, 5'h10}, 1'b1, 8'h00, 8'h44, 8'h80, 8'h18, 8'hFF},
      '{{bie_pkg::OP_BIT_CLR, 3'h0, 5'h10}, 1'b1, 8'hFF, 8'h44, 8'hFE, 8'h18, 8'hFF},
      '{{bie_pkg::OP_W_TO_F, 5'h10}, 1'b1, 8'h00, 8'h66, 8'h66, 8'h18, 8'hFF},
      '{{bie_pkg::OP_LIT_W, 8'h77}, 1'b0, 8'h00, 8'h11, 8'h77, 8'h18, 8'hFF},
      '{bie_pkg::INSN_OPTION, 1'b0, 8'h00, 8'h2A, 8'h2A, 8'h18, 8'h2A}
   };

   bie_core dut (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .option_out (option_out)
   );

   // Free-running 250 MHz clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; request held until ready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         n_errors++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd

   task automatic load(input logic [10:0] ad, input logic [11:0] w);
      wr(bie_pkg::A_PMEM, {5'h00, ad, 4'h0, w});
   endtask : load

   task automatic rst();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst

   // A stop abandons the cycle in flight; it is redone whole at the next start
   task automatic run_for(input int n);
      wr(bie_pkg::A_CTRL, 32'h1);
      repeat (n) @(posedge pclk);
      wr(bie_pkg::A_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
   endtask : run_for

   initial begin
      logic [31:0] r;
      logic [31:0] p1;
      logic [31:0] p2;
      logic        e;
      rst();
      rd(bie_pkg::A_CORE, r);
      chk(r, 32'h00FF1800);
      chk({24'h0, option_out}, 32'h000000FF);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      wr(bie_pkg::A_CORE, 32'h12345678);
      rd(bie_pkg::A_CORE, r);
      chk(r, 32'h00FF1800);
      foreach (rows[i]) begin
         rst();
         load(11'h000, {bie_pkg::OP_LIT_W, rows[i].a});
         load(11'h001, {bie_pkg::OP_W_TO_F, 5'h10});
         load(11'h002, {bie_pkg::OP_LIT_W, rows[i].b});
         load(11'h003, rows[i].op);
         load(11'h004, rows[i].post ? {bie_pkg::OP_MOV_F, 1'b0, 5'h10} : bie_pkg::INSN_NOP);
         load(11'h005, {bie_pkg::OP_GOTO, 9'h005});
         run_for(80);
         rd(bie_pkg::A_CORE, r);
         chk(r, {8'h00, rows[i].eopt, rows[i].est, rows[i].ew});
      end
      // Taken skip must flush the prefetched word, untaken one must not
      rst();
      load(11'h000, {bie_pkg::OP_LIT_W, 8'h33});
      load(11'h001, {bie_pkg::OP_ZERO_F, 5'h10});
      load(11'h002, {bie_pkg::OP_SKIP_CLR, 3'h0, 5'h10});
      load(11'h003, {bie_pkg::OP_LIT_W, 8'h11});
      load(11'h004, {bie_pkg::OP_SKIP_SET, 3'h0, 5'h10});
      load(11'h005, {bie_pkg::OP_AND_LIT, 8'h0F});
      load(11'h006, {bie_pkg::OP_GOTO, 9'h006});
      run_for(80);
      rd(bie_pkg::A_CORE, r);
      chk(r, 32'h00FF1803);
      // Call into a run of no-ops, then measure fetch rate and watchdog clear
      rst();
      for (int i = 0; i < 64; i++) load(i[10:0], bie_pkg::INSN_NOP);
      load(11'h000, {bie_pkg::OP_CALL, 8'h20});
      load(11'h030, bie_pkg::INSN_WDOG_CLR);
      load(11'h031, {bie_pkg::OP_GOTO, 9'h031});
      wr(bie_pkg::A_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      rd(bie_pkg::A_PCREG, p1);
      repeat (37) @(posedge pclk);
      rd(bie_pkg::A_PCREG, p2);
      chk({21'h0, p2[10:0] - p1[10:0]}, 32'hA);
      chk({21'h0, p1[26:16]}, 32'h1);
      chk({31'h0, p1[10:8] == 3'h0 && p1[7:0] > 8'h20 && p1[7:0] < 8'h28}, 32'h1);
      repeat (100) @(posedge pclk);
      wr(bie_pkg::A_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
      rd(bie_pkg::A_WDOG, r);
      chk({24'h0, r[7:0]}, 32'h0);
      chk({31'h0, r[15:8] < 8'h1E}, 32'h1);
      conclude();
   end
endmodule : test_baseline_instruction_executor

bind bie_core bie_core_asserts u_chk (
   .pclk       (pclk),
   .presetn    (presetn),
   .psel       (psel),
   .penable    (penable),
   .pwrite     (pwrite),
   .paddr      (paddr),
   .pwdata     (pwdata),
   .prdata     (prdata),
   .pready     (pready),
   .pslverr    (pslverr),
   .option_out (option_out)
);
`default_nettype wire
